// *** dmaxm_defines.svh ***
`ifndef DMAXM_DEFINES_SVH
`define DMAXM_DEFINES_SVH

`define DMAXM_ADDR_W 8
`define DMAXM_DATA_W 32
`define DMAXM_FIFO_W 32
`define DMAXM_FIFO_DEPTH 32
`define DMAXM_FIFO_AW 5

`define DMAXM_OFF_CTRL_WORD 8'h00
`define DMAXM_OFF_SRC_ADDR 8'h04
`define DMAXM_OFF_DST_ADDR 8'h08
`define DMAXM_OFF_XFER_CNT 8'h0C
`define DMAXM_OFF_CMD 8'h10
`define DMAXM_OFF_STATUS 8'h14

`define DMAXM_CW_SRC_INC 0
`define DMAXM_CW_SRC_SIZE 1
`define DMAXM_CW_SRC_LEN 4
`define DMAXM_CW_SRC_PROT 8
`define DMAXM_CW_SRC_CACHE 11
`define DMAXM_CW_DST_INC 14
`define DMAXM_CW_DST_SIZE 15
`define DMAXM_CW_DST_LEN 18
`define DMAXM_CW_DST_PROT 22
`define DMAXM_CW_DST_CACHE 25
`define DMAXM_CW_SWAP 28

`define DMAXM_CW_RESET 32'h0000_4001

`define DMAXM_BURST_FIXED 2'h0
`define DMAXM_BURST_INCR 2'h1
`define DMAXM_ERR_NONE 1'h0

`endif

// *** dmaxm_pkg.sv ***
package dmaxm_pkg;

  typedef enum logic [1:0] {
    DMAXM_ST_IDLE,
    DMAXM_ST_ADDR,
    DMAXM_ST_DATA
  } dmaxm_chan_st_t;

  typedef struct packed {
    logic src_inc;
    logic [2:0] src_size;
    logic [3:0] src_len;
    logic [2:0] src_prot;
    logic [2:0] src_cache;
    logic dst_inc;
    logic [2:0] dst_size;
    logic [3:0] dst_len;
    logic [2:0] dst_prot;
    logic [2:0] dst_cache;
    logic [2:0] swap;
  } dmaxm_ctrl_t;

endpackage : dmaxm_pkg

// *** dmaxm_fifo.sv ***
`timescale 1ns/1ns
`include "dmaxm_defines.svh"

module dmaxm_fifo #(
  parameter int WIDTH = `DMAXM_FIFO_W,
  parameter int DEPTH = `DMAXM_FIFO_DEPTH,
  parameter int AW = `DMAXM_FIFO_AW
) (
  // Clock, reset, enable and flush
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_flush,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dmaxm_fifo_st_t;

  dmaxm_fifo_st_t st_r;
  dmaxm_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign o_in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data = st_r.mem[st_r.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

endmodule : dmaxm_fifo

// *** dmaxm_swap.sv ***
`timescale 1ns/1ns
`include "dmaxm_defines.svh"

module dmaxm_swap (
  // Granule and data
  input wire logic [2:0] i_granule,
  input wire logic [`DMAXM_DATA_W-1:0] i_data,
  output logic [`DMAXM_DATA_W-1:0] o_data
);

  // Granules wider than the 32-bit data path act as a full word reversal.
  localparam int NB = `DMAXM_DATA_W / 8;

  for (genvar b = 0; b < NB; b++) begin : g_byte
    logic [1:0] idx;
    always_comb begin
      case (i_granule)
        3'h0: idx = 2'(b);
        3'h1: idx = 2'(b ^ 1);
        default: idx = 2'(b ^ 3);
      endcase
    end
    assign o_data[b*8 +: 8] = i_data[idx*8 +: 8];
  end

endmodule : dmaxm_swap

// *** dmaxm_top.sv ***
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "dmaxm_defines.svh"

// Contract
// - Source increment drives read burst type bit 0, default increment.
// - Source beat size 8 to 128 bits sets read size, default 8.
// - Source burst length 1 to 16 sets read length, default one beat.
// - Destination increment drives write burst type bit 0, default increment.
// - Destination beat size 8 to 128 bits sets write size, default 8.
// - Destination burst length 1 to 16 sets write length, default one.
// - Read cache bit 3 always low; only lower three bits act.
// - Write cache bit 2 always low; bits 3 and 1:0 act.
// - Channel holds an endian swap granule, default 8 bits, no swap.
// - Source and destination protection accept 0 to 7, default 0.
// - Active-low asynchronous reset; all logic on one clock.
// - Programming ports advance only while the programming clock enable is high.
// - Read and write lock fields held at zero always.
// - Two programming ports: one secure-only, one non-secure.
module dmaxm_top (
  // Clock, reset and enables
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_pclken,
  // Secure programming port
  input wire logic [`DMAXM_ADDR_W-1:0] i_s_addr,
  input wire logic [31:0] i_s_wdata,
  input wire logic i_s_wr,
  input wire logic i_s_rd,
  output logic [31:0] o_s_rdata,
  // Non-secure programming port
  input wire logic [`DMAXM_ADDR_W-1:0] i_ns_addr,
  input wire logic [31:0] i_ns_wdata,
  input wire logic i_ns_wr,
  input wire logic i_ns_rd,
  output logic [31:0] o_ns_rdata,
  // Read address channel
  output logic [31:0] o_araddr,
  output logic [1:0] o_arburst,
  output logic [3:0] o_arcache,
  output logic [3:0] o_arlen,
  output logic [2:0] o_arprot,
  output logic [2:0] o_arsize,
  output logic [1:0] o_arlock,
  output logic o_arvalid,
  input wire logic i_arready,
  // Read data channel
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rlast,
  input wire logic i_rvalid,
  output logic o_rready,
  // Write address channel
  output logic [31:0] o_awaddr,
  output logic [1:0] o_awburst,
  output logic [3:0] o_awcache,
  output logic [3:0] o_awlen,
  output logic [2:0] o_awprot,
  output logic [2:0] o_awsize,
  output logic [1:0] o_awlock,
  output logic o_awvalid,
  input wire logic i_awready,
  // Write data channel
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wlast,
  output logic o_wvalid,
  input wire logic i_wready,
  // Write response channel
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready
);

  typedef struct packed {
    dmaxm_pkg::dmaxm_ctrl_t ctrl;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [15:0] rd_left;
    logic [15:0] wr_left;
    logic [3:0] rbeat;
    logic [3:0] wbeat;
    dmaxm_pkg::dmaxm_chan_st_t rst_st;
    dmaxm_pkg::dmaxm_chan_st_t wst_st;
    logic wresp_wait;
    logic busy;
    logic err;
    logic ctrl_secure;
    logic [31:0] s_rdata;
    logic [31:0] ns_rdata;
  } dmaxm_st_t;

  dmaxm_st_t st_r;
  dmaxm_st_t st_nxt;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic [31:0] swapped;
  logic rd_push;
  logic w_pop;

  // Shared read mux for both programming ports.
  function automatic logic [31:0] reg_read(input dmaxm_st_t s, input logic [`DMAXM_ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `DMAXM_OFF_CTRL_WORD: begin
        v[`DMAXM_CW_SRC_INC] = s.ctrl.src_inc;
        v[`DMAXM_CW_SRC_SIZE +: 3] = s.ctrl.src_size;
        v[`DMAXM_CW_SRC_LEN +: 4] = s.ctrl.src_len;
        v[`DMAXM_CW_SRC_PROT +: 3] = s.ctrl.src_prot;
        v[`DMAXM_CW_SRC_CACHE +: 3] = s.ctrl.src_cache;
        v[`DMAXM_CW_DST_INC] = s.ctrl.dst_inc;
        v[`DMAXM_CW_DST_SIZE +: 3] = s.ctrl.dst_size;
        // Cache fields read back in their stored three-bit form, without the fixed-low bit.
        v[`DMAXM_CW_DST_LEN +: 4] = s.ctrl.dst_len;
        v[`DMAXM_CW_DST_PROT +: 3] = s.ctrl.dst_prot;
        v[`DMAXM_CW_DST_CACHE +: 3] = s.ctrl.dst_cache;
        v[`DMAXM_CW_SWAP +: 3] = s.ctrl.swap;
      end
      `DMAXM_OFF_SRC_ADDR: v = s.src_addr;
      `DMAXM_OFF_DST_ADDR: v = s.dst_addr;
      `DMAXM_OFF_XFER_CNT: v = {s.wr_left, s.rd_left};
      `DMAXM_OFF_STATUS: v = {28'h0000000, s.ctrl_secure, s.err, s.wresp_wait, s.busy};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_read

  // Decodes a written word into the control state; out-of-range sizes clamp to 128 bits.
  function automatic dmaxm_pkg::dmaxm_ctrl_t ctrl_decode(input logic [31:0] w);
    dmaxm_pkg::dmaxm_ctrl_t c;
    c.src_inc = w[`DMAXM_CW_SRC_INC];
    c.src_size = (w[`DMAXM_CW_SRC_SIZE +: 3] > 3'h4) ? 3'h4 : w[`DMAXM_CW_SRC_SIZE +: 3];
    c.src_len = w[`DMAXM_CW_SRC_LEN +: 4];
    c.src_prot = w[`DMAXM_CW_SRC_PROT +: 3];
    c.src_cache = w[`DMAXM_CW_SRC_CACHE +: 3];
    c.dst_inc = w[`DMAXM_CW_DST_INC];
    c.dst_size = (w[`DMAXM_CW_DST_SIZE +: 3] > 3'h4) ? 3'h4 : w[`DMAXM_CW_DST_SIZE +: 3];
    c.dst_len = w[`DMAXM_CW_DST_LEN +: 4];
    c.dst_prot = w[`DMAXM_CW_DST_PROT +: 3];
    c.dst_cache = w[`DMAXM_CW_DST_CACHE +: 3];
    c.swap = (w[`DMAXM_CW_SWAP +: 3] > 3'h4) ? 3'h4 : w[`DMAXM_CW_SWAP +: 3];
    return c;
  endfunction : ctrl_decode

  dmaxm_fifo #(
    .WIDTH(`DMAXM_FIFO_W),
    .DEPTH(`DMAXM_FIFO_DEPTH),
    .AW(`DMAXM_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_flush(1'b0),
    .i_in_valid(rd_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_rdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(w_pop),
    .o_out_data(fifo_out_data)
  );

  dmaxm_swap u_swap (
    .i_granule(st_r.ctrl.swap),
    .i_data(fifo_out_data),
    .o_data(swapped)
  );

  assign rd_push = o_rready && i_rvalid;
  assign o_rready = (st_r.rst_st == dmaxm_pkg::DMAXM_ST_DATA) && fifo_in_ready;
  assign o_wvalid = (st_r.wst_st == dmaxm_pkg::DMAXM_ST_DATA) && fifo_out_valid;
  assign w_pop = o_wvalid && i_wready;
  assign o_wdata = swapped;
  assign o_wstrb = 4'hF;
  assign o_wlast = (st_r.wbeat == st_r.ctrl.dst_len);
  assign o_bready = st_r.wresp_wait;
  assign o_arvalid = (st_r.rst_st == dmaxm_pkg::DMAXM_ST_ADDR);
  assign o_awvalid = (st_r.wst_st == dmaxm_pkg::DMAXM_ST_ADDR);

  assign o_araddr = st_r.src_addr;
  assign o_arburst = st_r.ctrl.src_inc ? `DMAXM_BURST_INCR : `DMAXM_BURST_FIXED;
  assign o_arsize = st_r.ctrl.src_size;
  assign o_arlen = st_r.ctrl.src_len;
  assign o_arprot = st_r.ctrl.src_prot;
  assign o_arcache = {1'b0, st_r.ctrl.src_cache};
  assign o_arlock = 2'h0;
  assign o_awaddr = st_r.dst_addr;
  assign o_awburst = st_r.ctrl.dst_inc ? `DMAXM_BURST_INCR : `DMAXM_BURST_FIXED;
  assign o_awsize = st_r.ctrl.dst_size;
  assign o_awlen = st_r.ctrl.dst_len;
  assign o_awprot = st_r.ctrl.dst_prot;
  assign o_awcache = {st_r.ctrl.dst_cache[2], 1'b0, st_r.ctrl.dst_cache[1:0]};
  assign o_awlock = 2'h0;
  assign o_s_rdata = st_r.s_rdata;
  assign o_ns_rdata = st_r.ns_rdata;

  always_comb begin
    logic [31:0] cmd_w;
    logic cmd_go;
    logic cmd_sec;
    logic [`DMAXM_ADDR_W-1:0] w_addr;
    cmd_w = 32'h0000_0000;
    cmd_go = 1'b0;
    cmd_sec = 1'b0;
    w_addr = '0;
    st_nxt = st_r;
    st_nxt.s_rdata = 32'h0000_0000;
    st_nxt.ns_rdata = 32'h0000_0000;

    // Programming ports; the secure port wins when both write in one cycle.
    if (i_pclken) begin
      if (i_s_rd) begin
        st_nxt.s_rdata = reg_read(st_r, i_s_addr);
      end
      if (i_ns_rd) begin
        st_nxt.ns_rdata = reg_read(st_r, i_ns_addr);
      end
      if (i_s_wr) begin
        cmd_w = i_s_wdata;
        w_addr = i_s_addr;
        cmd_sec = 1'b1;
        cmd_go = 1'b1;
      end else if (i_ns_wr && !st_r.ctrl_secure) begin
        cmd_w = i_ns_wdata;
        w_addr = i_ns_addr;
        cmd_go = 1'b1;
      end
    end

    // Settings may change only while the channel is idle.
    if (cmd_go && !st_r.busy) begin
      case (w_addr)
        `DMAXM_OFF_CTRL_WORD: begin
          st_nxt.ctrl = ctrl_decode(cmd_w);
          st_nxt.ctrl_secure = cmd_sec;
        end
        `DMAXM_OFF_SRC_ADDR: st_nxt.src_addr = cmd_w;
        `DMAXM_OFF_DST_ADDR: st_nxt.dst_addr = cmd_w;
        `DMAXM_OFF_XFER_CNT: begin
          st_nxt.rd_left = cmd_w[15:0];
          st_nxt.wr_left = cmd_w[15:0];
        end
        `DMAXM_OFF_CMD: begin
          if (cmd_w[0] && (st_r.rd_left != 16'h0000)) begin
            st_nxt.busy = 1'b1;
            st_nxt.err = `DMAXM_ERR_NONE;
            st_nxt.rst_st = dmaxm_pkg::DMAXM_ST_ADDR;
            st_nxt.wst_st = dmaxm_pkg::DMAXM_ST_ADDR;
          end
        end
        default: begin
        end
      endcase
    end

    // Read engine: one burst per count of rd_left.
    case (st_r.rst_st)
      dmaxm_pkg::DMAXM_ST_IDLE: begin
      end
      dmaxm_pkg::DMAXM_ST_ADDR: begin
        if (i_arready) begin
          st_nxt.rst_st = dmaxm_pkg::DMAXM_ST_DATA;
          st_nxt.rbeat = 4'h0;
        end
      end
      dmaxm_pkg::DMAXM_ST_DATA: begin
        if (rd_push) begin
          st_nxt.rbeat = st_r.rbeat + 4'h1;
          if (i_rresp[1]) begin
            st_nxt.err = 1'b1;
          end
          if (i_rlast) begin
            st_nxt.rd_left = st_r.rd_left - 16'h0001;
            if (st_r.ctrl.src_inc) begin
              st_nxt.src_addr = st_r.src_addr + ((32'(st_r.ctrl.src_len) + 32'h1) << st_r.ctrl.src_size);
            end
            st_nxt.rst_st = (st_r.rd_left == 16'h0001) ? dmaxm_pkg::DMAXM_ST_IDLE : dmaxm_pkg::DMAXM_ST_ADDR;
          end
        end
      end
      default: st_nxt.rst_st = dmaxm_pkg::DMAXM_ST_IDLE;
    endcase

    // Write engine: one burst per count of wr_left.
    case (st_r.wst_st)
      dmaxm_pkg::DMAXM_ST_IDLE: begin
      end
      dmaxm_pkg::DMAXM_ST_ADDR: begin
        if (i_awready) begin
          st_nxt.wst_st = dmaxm_pkg::DMAXM_ST_DATA;
          st_nxt.wbeat = 4'h0;
        end
      end
      dmaxm_pkg::DMAXM_ST_DATA: begin
        if (w_pop) begin
          st_nxt.wbeat = st_r.wbeat + 4'h1;
          if (o_wlast) begin
            st_nxt.wst_st = dmaxm_pkg::DMAXM_ST_IDLE;
            st_nxt.wresp_wait = 1'b1;
            if (st_r.ctrl.dst_inc) begin
              st_nxt.dst_addr = st_r.dst_addr + ((32'(st_r.ctrl.dst_len) + 32'h1) << st_r.ctrl.dst_size);
            end
          end
        end
      end
      default: st_nxt.wst_st = dmaxm_pkg::DMAXM_ST_IDLE;
    endcase

    if (st_r.wresp_wait && i_bvalid) begin
      st_nxt.wresp_wait = 1'b0;
      if (i_bresp[1]) begin
        st_nxt.err = 1'b1;
      end
      st_nxt.wr_left = st_r.wr_left - 16'h0001;
      if (st_r.wr_left == 16'h0001) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.wst_st = dmaxm_pkg::DMAXM_ST_ADDR;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.ctrl.src_inc <= 1'b1;
      st_r.ctrl.dst_inc <= 1'b1;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

endmodule : dmaxm_top

// *** dmaxm_checker.sv ***
`timescale 1ns/1ns
module dmaxm_checker (
  // Clock, reset and enables
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_pclken,
  // Secure read path
  input wire logic i_s_rd,
  input wire logic [31:0] o_s_rdata,
  // Address channels
  input wire logic [31:0] o_araddr,
  input wire logic [3:0] o_arcache,
  input wire logic [3:0] o_arlen,
  input wire logic [2:0] o_arsize,
  input wire logic [1:0] o_arlock,
  input wire logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] o_awaddr,
  input wire logic [3:0] o_awcache,
  input wire logic [3:0] o_awlen,
  input wire logic [2:0] o_awsize,
  input wire logic [1:0] o_awlock,
  input wire logic o_awvalid,
  input wire logic i_awready,
  // Write data
  input wire logic o_wlast,
  input wire logic o_wvalid,
  input wire logic i_wready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [3:0] beat_r;
  logic [3:0] beat_nxt;
  always_comb begin
    beat_nxt = beat_r;
    if (o_wvalid && i_wready) begin
      beat_nxt = o_wlast ? 4'h0 : beat_r + 4'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      beat_r <= 4'h0;
    end else begin
      beat_r <= beat_nxt;
    end
  end
  lock_zero_a: assert property (o_arlock == 2'h0 && o_awlock == 2'h0) else $error("lock field set");
  rd_cache_a: assert property (o_arvalid |-> !o_arcache[3]) else $error("read cache bit 3 set");
  wr_cache_a: assert property (o_awvalid |-> !o_awcache[2]) else $error("write cache bit 2 set");
  ar_hold_a: assert property (o_arvalid && !i_arready |=> o_arvalid && $stable(o_araddr) && $stable(o_arlen))
    else $error("read address dropped");
  aw_hold_a: assert property (o_awvalid && !i_awready |=> o_awvalid && $stable(o_awaddr) && $stable(o_awlen))
    else $error("write address dropped");
  size_range_a: assert property (o_arsize <= 3'h4 && o_awsize <= 3'h4) else $error("size code too big");
  rdata_idle_a: assert property (i_ce && !(i_s_rd && i_pclken) |=> o_s_rdata == 32'h0)
    else $error("read data not idle");
  wlast_count_a: assert property (o_wvalid && i_wready && o_wlast |-> beat_r == o_awlen)
    else $error("last beat misplaced");
  ar_hs_c: cover property (o_arvalid && i_arready);
  aw_hs_c: cover property (o_awvalid && i_awready);
  wlast_c: cover property (o_wvalid && i_wready && o_wlast);
endmodule : dmaxm_checker

bind dmaxm_top dmaxm_checker dmaxm_checker_i (.*);

// *** dmaxm_axi_mem.sv ***
`timescale 1ns/1ns
module dmaxm_axi_mem (
  // Clock, reset and test controls
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_stall,
  input wire logic i_err,
  // Read channels
  input wire logic [3:0] i_arlen,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic o_rlast,
  output logic o_rvalid,
  input wire logic i_rready,
  // Write channels
  input wire logic i_wvalid,
  input wire logic i_wlast,
  output logic o_ready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready
);
  logic tog_r;
  logic [4:0] left_r;
  logic [31:0] cnt_r;
  // While stalling, every channel accepts only on alternate cycles.
  assign o_ready = tog_r || !i_stall;
  assign o_arready = o_ready;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tog_r <= 1'b0;
      left_r <= 5'h00;
      cnt_r <= 32'h0;
      o_rdata <= 32'h0;
      o_rlast <= 1'b0;
      o_rvalid <= 1'b0;
      o_bresp <= 2'h0;
      o_bvalid <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (i_arvalid && o_arready) begin
        left_r <= {1'b0, i_arlen} + 5'h01;
      end
      // A released data bus shows the inverse of its last word.
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_rdata <= ~o_rdata;
      end else if (!o_rvalid && left_r != 5'h00 && o_ready) begin
        o_rvalid <= 1'b1;
        o_rdata <= cnt_r;
        cnt_r <= cnt_r + 32'h1;
        o_rlast <= left_r == 5'h01;
        left_r <= left_r - 5'h01;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end else if (i_wvalid && o_ready && i_wlast) begin
        o_bvalid <= 1'b1;
        o_bresp <= i_err ? 2'h2 : 2'h0;
      end
    end
  end
endmodule : dmaxm_axi_mem

// *** tb.sv ***
`timescale 1ns/1ns
`include "dmaxm_defines.svh"
module tb;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_pclken = 1'b1;
  logic i_s_wr = 1'b0, i_s_rd = 1'b0, i_ns_wr = 1'b0, i_ns_rd = 1'b0;
  logic [7:0] i_s_addr = 8'h00, i_ns_addr = 8'h00;
  logic [31:0] i_s_wdata = 32'h0, i_ns_wdata = 32'h0, o_s_rdata, o_ns_rdata, o_araddr, o_awaddr, i_rdata, o_wdata;
  logic [1:0] o_arburst, o_arlock, i_rresp, o_awburst, o_awlock, i_bresp;
  logic [3:0] o_arcache, o_arlen, o_awcache, o_awlen, o_wstrb;
  logic [2:0] o_arprot, o_arsize, o_awprot, o_awsize;
  logic o_arvalid, i_arready, i_rlast, i_rvalid, o_rready, o_awvalid, i_awready;
  logic o_wlast, o_wvalid, i_wready, i_bvalid, o_bready;
  logic stall = 1'b0, err = 1'b0, rd_tag = 1'b0, rd_d1 = 1'b0, rd_ns = 1'b0;
  logic [31:0] ar_q[$], aw_q[$], w_q[$], rd_q[$];
  int error_cnt = 0, comparisons = 0, cyc = 0, wnum = 0, seed = 32'h80a3;
  dmaxm_pkg::dmaxm_ctrl_t c;
  assign i_rresp = 2'h0;
  assign i_awready = i_arready;
  dmaxm_top dmaxm_top_i (.*);
  dmaxm_axi_mem dmaxm_axi_mem_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_stall(stall), .i_err(err),
    .i_arlen(o_arlen), .i_arvalid(o_arvalid), .o_arready(i_arready), .o_rdata(i_rdata), .o_rlast(i_rlast),
    .o_rvalid(i_rvalid), .i_rready(o_rready), .i_wvalid(o_wvalid), .i_wlast(o_wlast), .o_ready(i_wready),
    .o_bresp(i_bresp), .o_bvalid(i_bvalid), .i_bready(o_bready));
  always #4 i_clk = ~i_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge i_clk) begin
    if (rd_d1) check("read data", rd_ns ? o_ns_rdata : o_s_rdata, rd_q.pop_front());
    if (o_arvalid && i_arready) check("read address", o_araddr, ar_q.pop_front());
    if (o_awvalid && i_awready) check("write address", o_awaddr, aw_q.pop_front());
    if (o_wvalid && i_wready) check("write data", o_wdata, w_q.pop_front());
    if (o_wvalid && i_wready) check("write strobe", {28'h0, o_wstrb}, 32'hF);
    rd_d1 <= rd_tag;
    rd_ns <= i_ns_rd;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic wr(input logic ns, input logic [7:0] a, input logic [31:0] d, input logic en);
    @(posedge i_clk);
    {i_pclken, i_ns_wr, i_s_wr} <= {en, ns, !ns};
    {i_s_addr, i_ns_addr, i_s_wdata, i_ns_wdata} <= {a, a, d, d};
    @(posedge i_clk);
    {i_pclken, i_ns_wr, i_s_wr} <= 3'h4;
  endtask : wr
  task automatic rd(input logic ns, input logic [7:0] a, input logic [31:0] e, input logic tag);
    @(posedge i_clk);
    {rd_tag, i_ns_rd, i_s_rd, i_s_addr, i_ns_addr} <= {tag, ns, !ns, a, a};
    if (tag) rd_q.push_back(e);
    @(posedge i_clk);
    {rd_tag, i_ns_rd, i_s_rd} <= 3'h0;
  endtask : rd
  function automatic logic [31:0] pack(input dmaxm_pkg::dmaxm_ctrl_t k);
    return (32'(k.src_inc) << `DMAXM_CW_SRC_INC) | (32'(k.src_size) << `DMAXM_CW_SRC_SIZE)
      | (32'(k.src_len) << `DMAXM_CW_SRC_LEN) | (32'(k.src_prot) << `DMAXM_CW_SRC_PROT)
      | (32'(k.src_cache) << `DMAXM_CW_SRC_CACHE) | (32'(k.dst_inc) << `DMAXM_CW_DST_INC)
      | (32'(k.dst_size) << `DMAXM_CW_DST_SIZE) | (32'(k.dst_len) << `DMAXM_CW_DST_LEN)
      | (32'(k.dst_prot) << `DMAXM_CW_DST_PROT) | (32'(k.dst_cache) << `DMAXM_CW_DST_CACHE);
  endfunction : pack
  task automatic attrs(input dmaxm_pkg::dmaxm_ctrl_t k);
    #1;
    check("read burst", {o_arburst, o_arsize, o_arlen}, {1'b0, k.src_inc, k.src_size, k.src_len});
    check("write burst", {o_awburst, o_awsize, o_awlen}, {1'b0, k.dst_inc, k.dst_size, k.dst_len});
    check("read attrs", {o_arprot, o_arcache}, {k.src_prot, 1'b0, k.src_cache});
    check("write attrs", {o_awprot, o_awcache}, {k.dst_prot, k.dst_cache[2], 1'b0, k.dst_cache[1:0]});
  endtask : attrs
  task automatic xfer(input logic inc, input logic [3:0] len, input int cnt, input logic bad, input logic [2:0] sw);
    logic [31:0] d;
    c = '0;
    {c.src_inc, c.dst_inc, c.src_size, c.dst_size, c.src_len, c.dst_len} = {inc, 1'b1, 3'h2, 3'h2, len, len};
    wr(1'b0, `DMAXM_OFF_CTRL_WORD, pack(c) | (32'(sw) << `DMAXM_CW_SWAP), 1'b1);
    wr(1'b0, `DMAXM_OFF_SRC_ADDR, 32'h1000, 1'b1);
    wr(1'b0, `DMAXM_OFF_DST_ADDR, 32'h2000, 1'b1);
    wr(1'b0, `DMAXM_OFF_XFER_CNT, cnt, 1'b1);
    for (int b = 0; b < cnt; b++) begin
      ar_q.push_back(32'h1000 + (inc ? b * (len + 1) * 4 : 0));
      aw_q.push_back(32'h2000 + b * (len + 1) * 4);
      for (int k = 0; k <= len; k++) begin
        d = wnum++;
        w_q.push_back(sw == 3'h0 ? d : sw == 3'h1 ? {d[23:16], d[31:24], d[7:0], d[15:8]}
          : {d[7:0], d[15:8], d[23:16], d[31:24]});
      end
    end
    {stall, err} <= {bad, bad};
    wr(1'b0, `DMAXM_OFF_CMD, 32'h1, 1'b1);
    for (int n = 0; n < 600 && dmaxm_top_i.o_s_rdata !== 32'h8 && dmaxm_top_i.o_s_rdata !== 32'hC; n++) begin
      rd(1'b0, `DMAXM_OFF_STATUS, 32'h0, 1'b0);
      @(posedge i_clk);
    end
    rd(1'b0, `DMAXM_OFF_STATUS, {28'h0, 1'b1, bad, 2'h0}, 1'b1);
    @(posedge i_clk);
    check("queues empty", ar_q.size() + aw_q.size() + w_q.size(), 32'h0);
    $display("transfer test done");
  endtask : xfer
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    c = '0;
    {c.src_inc, c.dst_inc} = 2'h3;
    attrs(c);
    rd(1'b0, `DMAXM_OFF_CTRL_WORD, pack(c), 1'b1);
    $display("reset test done");
    wr(1'b1, `DMAXM_OFF_SRC_ADDR, 32'h5A5A_0F0C, 1'b1);
    rd(1'b1, `DMAXM_OFF_SRC_ADDR, 32'h5A5A_0F0C, 1'b1);
    wr(1'b0, `DMAXM_OFF_CTRL_WORD, pack(c), 1'b1);
    wr(1'b1, `DMAXM_OFF_CTRL_WORD, 32'h0FFF_FFFF, 1'b1);
    wr(1'b0, `DMAXM_OFF_CTRL_WORD, 32'h0000_0102, 1'b0);
    rd(1'b0, `DMAXM_OFF_CTRL_WORD, pack(c), 1'b1);
    rd(1'b0, 8'h40, 32'h0, 1'b1);
    $display("port test done");
    for (int i = 0; i < 5; i++) begin
      c = dmaxm_pkg::dmaxm_ctrl_t'($random(seed));
      {c.src_size, c.dst_size, c.swap} = {3'(i), 3'(4 - i), 3'(i)};
      if (i == 0) {c.src_len, c.dst_len} = 8'h0F;
      wr(1'b0, `DMAXM_OFF_CTRL_WORD, pack(c) | (32'(c.swap) << `DMAXM_CW_SWAP), 1'b1);
      attrs(c);
      rd(1'b0, `DMAXM_OFF_CTRL_WORD, pack(c) | (32'(c.swap) << `DMAXM_CW_SWAP), 1'b1);
    end
    wr(1'b0, `DMAXM_OFF_CTRL_WORD, 32'h0000_000E, 1'b1);
    #1 check("clamped size", {29'h0, o_arsize}, 32'h4);
    $display("attribute test done");
    xfer(1'b1, 4'h3, 2, 1'b0, 3'h1);
    xfer(1'b0, 4'hF, 2, 1'b1, 3'h4);
    xfer(1'b1, 4'h0, 3, 1'b0, 3'h0);
    final_report();
  end
endmodule : tb
